// >>> core/tsf_desc_decode.sv
// What this block does
// RULE_01 - Code 00: sixteen-address table, perfect receive filtering.
// RULE_02 - Code 01: 512-bit hash table plus one perfect physical address.
// RULE_03 - Code 01: multicast hashed, physical compared exactly with stored address.
// RULE_04 - Code 10: sixteen-address table, inverse matching accepts non-matching frames.
// RULE_05 - Code 11: hash table only, all destinations filtered by hash.
// RULE_06 - Filter bits used only when setup flag set; ignored otherwise.
// RULE_07 - Third word is buffer one address, any byte alignment.
// RULE_08 - Fourth word is buffer two address, any byte alignment.
// RULE_09 - Filter code high bit at 28, low bit at 22.
// RULE_10 - Chained flag makes fourth word the next descriptor address.
// RULE_11 - Fetch drops leading bytes below the start offset of a buffer.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

`include "tsf_map.svh"

module tsf_desc_decode
	import tsf_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata,
	// Fetched buffer words and aligned output stream
	input  wire logic        word_valid,
	input  wire logic [31:0] word_data,
	output logic             byte_valid,
	output logic [7:0]       byte_data,
	// Filter configuration towards the receive address filter
	output logic             filt_update,
	output logic             filt_table_perfect,
	output logic             filt_inverse,
	output logic             filt_hash_multicast,
	output logic             filt_hash_physical,
	output logic             filt_single_perfect,
	output logic [4:0]       filt_perfect_count,
	output logic [9:0]       filt_hash_bits,
	// Buffer addresses
	output logic [31:0]      buf_one_addr,
	output logic [31:0]      buf_two_addr,
	output logic             buf_two_valid,
	output logic [31:0]      next_desc_addr,
	output logic             next_desc_valid
);
	import tsf_pkg::*;

	// ----------------------------------------------------------------
	// Descriptor words written by software
	// ----------------------------------------------------------------
	tsf_word_t  tx_desc_control_word;
	tsf_word_t  tx_desc_buffer_one_addr;
	tsf_word_t  tx_desc_buffer_two_addr;
	logic       is_setup;
	logic       second_addr_chained_flag;
	tsf_mode_e  mode;
	tsf_mode_e  cur_mode;
	logic       start_pulse;
	logic       which_buf;
	logic [1:0] start_offset;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = wr && (a == off);
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_desc_control_word    <= `TSF_RESET_WORD;
			tx_desc_buffer_one_addr <= `TSF_RESET_WORD;
			tx_desc_buffer_two_addr <= `TSF_RESET_WORD;
		end else begin
			if (hit(addr, `TSF_OFF_CONTROL))
				tx_desc_control_word <= wdata;
			if (hit(addr, `TSF_OFF_BUF_ONE))
				tx_desc_buffer_one_addr <= wdata; // RULE_07
			if (hit(addr, `TSF_OFF_BUF_TWO))
				tx_desc_buffer_two_addr <= wdata; // RULE_08
		end
	end

	// ----------------------------------------------------------------
	// Filtering-type decode
	// ----------------------------------------------------------------
	tsf_mode_decode u_mode (
		.ctrl     (tx_desc_control_word), // RULE_09
		.is_setup (is_setup),
		.mode     (mode),
		.chained  (second_addr_chained_flag)
	);

	// Only a setup descriptor may change the filter; ordinary frames keep it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur_mode    <= TSF_MODE_PERFECT;
			filt_update <= 1'b0;
		end else begin
			filt_update <= 1'b0;
			if (hit(addr, `TSF_OFF_START) && is_setup) begin // RULE_06
				cur_mode    <= mode;
				filt_update <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			filt_table_perfect  <= 1'b1;
			filt_inverse        <= 1'b0;
			filt_hash_multicast <= 1'b0;
			filt_hash_physical  <= 1'b0;
			filt_single_perfect <= 1'b0;
			filt_perfect_count  <= 5'(`TSF_PERFECT_ENTRIES);
			filt_hash_bits      <= 10'h000;
		end else begin
			case (cur_mode)
				TSF_MODE_PERFECT: begin
					filt_table_perfect  <= 1'b1; // RULE_01
					filt_inverse        <= 1'b0;
					filt_hash_multicast <= 1'b0;
					filt_hash_physical  <= 1'b0;
					filt_single_perfect <= 1'b0;
					filt_perfect_count  <= 5'(`TSF_PERFECT_ENTRIES);
					filt_hash_bits      <= 10'h000;
				end
				TSF_MODE_HASH_ONE: begin
					filt_table_perfect  <= 1'b0; // RULE_02
					filt_inverse        <= 1'b0;
					filt_hash_multicast <= 1'b1; // RULE_03
					filt_hash_physical  <= 1'b0;
					filt_single_perfect <= 1'b1; // RULE_03
					filt_perfect_count  <= 5'h01;
					filt_hash_bits      <= 10'(`TSF_HASH_BITS);
				end
				TSF_MODE_INVERSE: begin
					filt_table_perfect  <= 1'b1; // RULE_04
					filt_inverse        <= 1'b1; // RULE_04
					filt_hash_multicast <= 1'b0;
					filt_hash_physical  <= 1'b0;
					filt_single_perfect <= 1'b0;
					filt_perfect_count  <= 5'(`TSF_PERFECT_ENTRIES);
					filt_hash_bits      <= 10'h000;
				end
				default: begin
					filt_table_perfect  <= 1'b0; // RULE_05
					filt_inverse        <= 1'b0;
					filt_hash_multicast <= 1'b1; // RULE_05
					filt_hash_physical  <= 1'b1; // RULE_05
					filt_single_perfect <= 1'b0;
					filt_perfect_count  <= 5'h00;
					filt_hash_bits      <= 10'(`TSF_HASH_BITS);
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Buffer and next-descriptor addresses
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			buf_one_addr    <= `TSF_RESET_WORD;
			buf_two_addr    <= `TSF_RESET_WORD;
			buf_two_valid   <= 1'b0;
			next_desc_addr  <= `TSF_RESET_WORD;
			next_desc_valid <= 1'b0;
		end else begin
			buf_one_addr    <= tx_desc_buffer_one_addr; // RULE_07
			buf_two_addr    <= tx_desc_buffer_two_addr; // RULE_08
			buf_two_valid   <= !second_addr_chained_flag; // RULE_10
			next_desc_addr  <= tx_desc_buffer_two_addr;
			next_desc_valid <= second_addr_chained_flag; // RULE_10
		end
	end

	// ----------------------------------------------------------------
	// Buffer fetch alignment
	// ----------------------------------------------------------------
	// Writing the stream offset selects buffer one (bit 0 low) or two.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			which_buf <= 1'b0;
		end else if (hit(addr, `TSF_OFF_STREAM)) begin
			which_buf <= wdata[0];
		end
	end

	always_comb begin
		start_pulse  = hit(addr, `TSF_OFF_STREAM);
		start_offset = wdata[0] ? tx_desc_buffer_two_addr[1:0]
		                        : tx_desc_buffer_one_addr[1:0];
	end

	tsf_byte_align u_align (
		.clk       (clk),
		.rst       (rst),
		.start     (start_pulse), // RULE_11
		.offset    (start_offset),
		.in_valid  (word_valid),
		.in_word   (word_data),
		.out_valid (byte_valid),
		.out_byte  (byte_data)
	);

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			case (addr)
				`TSF_OFF_CONTROL:   rdata <= tx_desc_control_word;
				`TSF_OFF_BUF_ONE:   rdata <= tx_desc_buffer_one_addr;
				`TSF_OFF_BUF_TWO:   rdata <= tx_desc_buffer_two_addr;
				`TSF_OFF_STATUS:    rdata <= {27'h0, which_buf, next_desc_valid,
				                              is_setup, cur_mode};
				`TSF_OFF_NEXT_DESC: rdata <= next_desc_addr;
				default:            rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

endmodule

`default_nettype wire

// >>> core/tsf_map.svh
`ifndef TSF_MAP_SVH
`define TSF_MAP_SVH

// ----------------------------------------------------------------
// Control word field positions
// ----------------------------------------------------------------
`define TSF_FT_HIGH_BIT     28
`define TSF_FT_LOW_BIT      22
`define TSF_SETUP_BIT       27
`define TSF_CHAINED_BIT     24
`define TSF_END_RING_BIT    25

// ----------------------------------------------------------------
// Filtering-type codes and reset values
// ----------------------------------------------------------------
`define TSF_FT_PERFECT      2'h0
`define TSF_FT_HASH_ONE     2'h1
`define TSF_FT_INVERSE      2'h2
`define TSF_FT_HASH_ONLY    2'h3
`define TSF_PERFECT_ENTRIES 16
`define TSF_HASH_BITS       512
`define TSF_RESET_WORD      32'h0000_0000

// ----------------------------------------------------------------
// Register port offsets
// ----------------------------------------------------------------
`define TSF_OFF_CONTROL     4'h0
`define TSF_OFF_BUF_ONE     4'h1
`define TSF_OFF_BUF_TWO     4'h2
`define TSF_OFF_STATUS      4'h3
`define TSF_OFF_NEXT_DESC   4'h4
`define TSF_OFF_START       4'h5
`define TSF_OFF_STREAM      4'h6

`endif

// >>> core/tsf_pkg.sv
package tsf_pkg;

	typedef enum logic [1:0] {
		TSF_MODE_PERFECT,
		TSF_MODE_HASH_ONE,
		TSF_MODE_INVERSE,
		TSF_MODE_HASH_ONLY
	} tsf_mode_e;

	typedef logic [31:0] tsf_word_t;

endpackage

// >>> core/tsf_mode_decode.sv
`timescale 1ns/100ps
`default_nettype none

`include "tsf_map.svh"

module tsf_mode_decode
	import tsf_pkg::*;
(
	// Descriptor control word
	input  wire logic [31:0]        ctrl,
	// Decoded mode
	output logic                    is_setup,
	output tsf_pkg::tsf_mode_e      mode,
	output logic                    chained
);
	logic [1:0] code;

	always_comb begin
		code     = {ctrl[`TSF_FT_HIGH_BIT], ctrl[`TSF_FT_LOW_BIT]};
		is_setup = ctrl[`TSF_SETUP_BIT];
		chained  = ctrl[`TSF_CHAINED_BIT];
		case (code)
			`TSF_FT_PERFECT:  mode = TSF_MODE_PERFECT;
			`TSF_FT_HASH_ONE: mode = TSF_MODE_HASH_ONE;
			`TSF_FT_INVERSE:  mode = TSF_MODE_INVERSE;
			default:          mode = TSF_MODE_HASH_ONLY;
		endcase
	end

endmodule

`default_nettype wire

// >>> core/tsf_byte_align.sv
`timescale 1ns/100ps
`default_nettype none

module tsf_byte_align (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Control
	input  wire logic        start,
	input  wire logic [1:0]  offset,
	// Incoming bus words
	input  wire logic        in_valid,
	input  wire logic [31:0] in_word,
	// Aligned byte stream
	output logic             out_valid,
	output logic [7:0]       out_byte
);
	logic [1:0] lane;
	logic       first;
	logic [1:0] skip;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			skip  <= 2'h0;
			first <= 1'b0;
		end else if (start) begin
			skip  <= offset;
			first <= 1'b1;
		end else if (in_valid) begin
			first <= 1'b0;
		end
	end

	// Leading bytes below the start offset are dropped only in the first word.
	always_comb begin
		lane = first ? skip : 2'h0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_byte  <= 8'h00;
		end else begin
			out_valid <= in_valid;
			out_byte  <= in_word[{lane, 3'h0} +: 8];
		end
	end

endmodule

`default_nettype wire

// >>> tb/tsf_desc_decode_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tsf_desc_decode_monitor (
	// Clock, reset and register port
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [3:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	// Filter and address outputs
	input wire logic        filt_update,
	input wire logic        filt_table_perfect,
	input wire logic        filt_inverse,
	input wire logic        filt_hash_multicast,
	input wire logic        filt_hash_physical,
	input wire logic        filt_single_perfect,
	input wire logic [4:0]  filt_perfect_count,
	input wire logic [9:0]  filt_hash_bits,
	input wire logic [31:0] buf_one_addr,
	input wire logic [31:0] buf_two_addr,
	input wire logic        buf_two_valid,
	input wire logic        next_desc_valid
);
	logic [31:0] ctl;
	logic        go;
	logic [1:0]  code;
	logic [4:0]  flags;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctl <= 32'h0;
		end else if (wr && addr == 4'h0) begin
			ctl <= wdata;
		end
	end
	// The mode code is split over two loose bits of the control word.
	assign go = wr && addr == 4'h5 && ctl[27];
	assign code = {ctl[28], ctl[22]};
	assign flags = {filt_table_perfect, filt_inverse, filt_hash_multicast, filt_hash_physical,
		filt_single_perfect};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_update_pulse:
		assert property (go |=> filt_update) else $error("no update after setup start");
	chk_plain_ignored:
		assert property (wr && addr == 4'h5 && !ctl[27] |=> !filt_update ##1 !filt_update)
		else $error("update on ordinary descriptor");
	chk_perfect_mode:
		assert property (go && code == 2'h0 |=> ##1 flags == 5'h10 && filt_perfect_count == 5'h10)
		else $error("perfect mode wrong");
	chk_hash_one:
		assert property (go && code == 2'h1 |-> ##2 flags == 5'h05 && filt_hash_bits == 10'h200)
		else $error("hash plus one mode wrong");
	chk_inverse_mode:
		assert property (go && code == 2'h2 |=> ##1 flags == 5'h18 && filt_perfect_count == 5'h10)
		else $error("inverse mode wrong");
	chk_hash_only:
		assert property (go && code == 2'h3 ##1 1'b1 |=> flags == 5'h06 && filt_perfect_count == 5'h00)
		else $error("hash only mode wrong");
	chk_buf_one:
		assert property (wr && addr == 4'h1 |-> ##2 buf_one_addr == $past(wdata, 2))
		else $error("buffer one address wrong");
	chk_buf_two:
		assert property (wr && addr == 4'h2 |-> ##2 buf_two_addr == $past(wdata, 2))
		else $error("buffer two address wrong");
	chk_chain_select:
		assert property (wr && addr == 4'h0 |-> ##2
			next_desc_valid == $past(ctl[24]) && buf_two_valid != $past(ctl[24]))
		else $error("chain selection wrong");
	chk_rdata_idle:
		assert property (!rd |=> rdata == 32'h0) else $error("read data outside read");
	cover property (go && code == 2'h3);
	cover property (wr && addr == 4'h5 && !ctl[27]);
	cover property (rd && addr == 4'h4 ##1 rdata != 32'h0);
endmodule
`default_nettype wire

// >>> tb/tsf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module tsf_host_model #(
	parameter logic [31:0] W0 = 32'h4433_2211,
	parameter logic [31:0] W1 = 32'h8877_6655
) (
	// Clock, reset and request
	input wire logic         clk,
	input wire logic         rst,
	input wire logic         go,
	// Fetched little-endian words
	output logic             word_valid,
	output logic [31:0]      word_data
);
	logic more;
	// Data lines toggle when idle so a stale word is never mistaken for a fresh one.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			more <= 1'b0;
			word_valid <= 1'b0;
			word_data <= 32'h0;
		end else if (go) begin
			more <= 1'b1;
			word_valid <= 1'b1;
			word_data <= W0;
		end else if (more) begin
			more <= 1'b0;
			word_valid <= 1'b1;
			word_data <= W1;
		end else begin
			word_valid <= 1'b0;
			word_data <= ~word_data;
		end
	end
endmodule
`default_nettype wire

// >>> tb/tsf_desc_decode_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value %s exp %h got %h", nm, exp, got); end end
module tsf_desc_decode_tb;
	logic        clk, rst, wr, rd, word_valid, host_go, byte_valid, filt_update;
	logic        filt_table_perfect, filt_inverse, filt_hash_multicast, filt_hash_physical;
	logic        filt_single_perfect, buf_two_valid, next_desc_valid;
	logic [3:0]  addr;
	logic [7:0]  byte_data;
	logic [4:0]  filt_perfect_count;
	logic [9:0]  filt_hash_bits;
	logic [31:0] wdata, rdata, word_data, got, buf_one_addr, buf_two_addr, next_desc_addr;
	logic [19:0] filt_exp [4] = '{{5'h10, 5'h10, 10'h0}, {5'h05, 5'h01, 10'h200},
		{5'h18, 5'h10, 10'h0}, {5'h06, 5'h00, 10'h200}};
	wire logic [19:0] filt_now = {filt_table_perfect, filt_inverse, filt_hash_multicast,
		filt_hash_physical, filt_single_perfect, filt_perfect_count, filt_hash_bits};
	int          miscompares = 0;
	int          checks = 0;
	tsf_desc_decode DUT (.*);
	tsf_host_model host (.clk, .rst, .go(host_go), .word_valid, .word_data);
	function automatic logic [31:0] mk_ctl(input logic [1:0] c, input logic setup, input logic chain);
		mk_ctl = 32'h0;
		mk_ctl[28] = c[1];
		mk_ctl[22] = c[0];
		mk_ctl[27] = setup;
		mk_ctl[24] = chain;
	endfunction
	task automatic put(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic get(input logic [3:0] a);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		@(posedge clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic summarize();
		if (miscompares == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#200000;
		miscompares++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		host_go = 1'b0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		idle(1);
		`CHECK("reset filter", filt_exp[0], filt_now)
		// ----------------------------------------------------------------
		// Every mode, changed on each pass, with unaligned buffer addresses except buffer one on the first pass and buffer two on the third
		// ----------------------------------------------------------------
		for (int i = 3; i >= 0; i--) begin
			put(4'h0, mk_ctl(2'(i), 1'b1, 1'b0));
			put(4'h1, 32'h1000_0001 + i);
			put(4'h2, 32'h2000_0003 + i);
			put(4'h5, 32'h0);
			idle(0);
			`CHECK("update", 1'b1, filt_update)
			idle(1);
			`CHECK("filter mode", filt_exp[i], filt_now)
			`CHECK("buf one", 32'h1000_0001 + i, buf_one_addr)
			`CHECK("buf two", 32'h2000_0003 + i, buf_two_addr)
			`CHECK("chain flags", 2'b01, {next_desc_valid, buf_two_valid})
			get(4'h3);
			`CHECK("status", {1'b1, 2'(i)}, got[2:0])
		end
		put(4'h0, mk_ctl(2'h3, 1'b0, 1'b0));
		put(4'h5, 32'h0);
		idle(0);
		`CHECK("plain update", 1'b0, filt_update)
		idle(1);
		`CHECK("plain filter", filt_exp[0], filt_now)
		put(4'h0, mk_ctl(2'h0, 1'b0, 1'b1));
		put(4'h2, 32'h2000_0042);
		idle(2);
		`CHECK("chained", 34'h2_2000_0042, {next_desc_valid, buf_two_valid, next_desc_addr})
		get(4'h4);
		`CHECK("next desc", 32'h2000_0042, got)
		get(4'hf);
		`CHECK("unmapped", 32'h0, got)
		// ----------------------------------------------------------------
		// Stream from buffer one (offset three), then buffer two (offset two)
		// ----------------------------------------------------------------
		for (int b = 0; b < 2; b++) begin
			if (b == 0)
				put(4'h1, 32'h3000_0003);
			idle(2);
			put(4'h6, 32'(b));
			idle(2);
			host_go <= 1'b1;
			@(posedge clk);
			host_go <= 1'b0;
			for (int k = 0; k < 2; k++) begin
				for (int t = 0; t < 8 && byte_valid !== 1'b1; t++) begin
					@(posedge clk);
					#1;
				end
				`CHECK("stream byte", k ? 8'h55 : (b ? 8'h33 : 8'h44), byte_data)
				@(posedge clk);
				#1;
			end
			get(4'h3);
			`CHECK("buffer select", 1'(b), got[4])
		end
		summarize();
	end
endmodule
bind tsf_desc_decode tsf_desc_decode_monitor u_mon (.*);
`undef CHECK
`default_nettype wire
